// ### logic/wdt_core.sv
// Watchdog timer core with register port and interrupt status
`timescale 1ns/1ps
`default_nettype none
`include "wdt_consts.svh"
module wdt_core #(
  parameter int CNT_W = `WDT_CNT_W
) (
  input  wire logic       clock_in,         // 20 MHz clock
  input  wire logic       rst_b_in,         // System reset, low
  input  wire logic [7:0] addr_in,          // Register address
  input  wire logic [7:0] wdata_in,         // Write data
  input  wire logic       wr_in,            // Write strobe
  input  wire logic       rd_in,            // Read strobe
  output logic      [7:0] rdata_out,        // Read data, next cycle
  input  wire logic       cpu_tick_in,      // CPU clock tick
  input  wire logic       loco_tick_in,     // Low-speed osc tick
  input  wire logic       stop_mode_in,     // CPU in stop mode
  input  wire logic       wait_mode_in,     // CPU in wait mode
  input  wire logic       auto_start_select_in,       // Option strap
  input  wire logic       protect_after_reset_select_in, // Strap
  output logic            wdt_reset_out,    // Watchdog reset pulse
  output logic            irq_out           // Level interrupt
);
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  wdt_pkg::wdt_ref_state_t ref_state;
  wdt_pkg::wdt_ref_state_t next_ref_state;
  logic [CNT_W-1:0]        cnt;
  logic                    strap_done;
  logic                    running;
  logic                    protect;
  logic                    presc_sel;
  logic                    urst_sel;
  logic [`WDT_EV_W-1:0]    status;
  logic [`WDT_EV_W-1:0]    enable;
  logic [`WDT_EV_W-1:0]    ev_set;
  logic                    tick_src;
  logic                    halted;
  logic                    cnt_run;
  logic                    count_pulse;
  logic                    underflow;
  logic                    refresh_hit;
  logic                    reload;
  logic                    wr_refresh;

  assign wr_refresh = wr_in && (addr_in == `WDT_ADDR_REFRESH);

  // Protection switches to the oscillator so a stopped CPU clock
  // cannot freeze the watchdog
  assign tick_src = protect ? loco_tick_in : cpu_tick_in;      // RL3
  assign halted   = !protect && (stop_mode_in || wait_mode_in); // RL6
  assign cnt_run  = running && !halted;

  wdt_presc u_presc (
    .clock_in  (clock_in),
    .rst_b_in  (rst_b_in),
    .tick_in   (tick_src && cnt_run),
    .clr_in    (reload),
    .sel_in    (presc_sel),
    .pulse_out (count_pulse)
  );

  // A refresh in the same cycle beats the last step
  assign underflow   = count_pulse && (cnt == '0) && !refresh_hit;
  assign refresh_hit = wr_refresh && (wdata_in == `WDT_REFRESH_FIRE)
                       && (ref_state == wdt_pkg::wdt_ref_armed);   // RL4
  assign reload      = underflow || refresh_hit;

  // Refresh sequence: 00h arms, FFh fires, anything else disarms
  always_comb begin
    next_ref_state = ref_state;
    if (wr_refresh) begin
      if (wdata_in == `WDT_REFRESH_ARM) begin
        next_ref_state = wdt_pkg::wdt_ref_armed;                   // RL4
      end else begin
        next_ref_state = wdt_pkg::wdt_ref_idle;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ref_state <= wdt_pkg::wdt_ref_idle;
    end else begin
      case (ref_state)
        wdt_pkg::wdt_ref_idle:  ref_state <= next_ref_state;
        wdt_pkg::wdt_ref_armed: ref_state <= next_ref_state;
        default:                ref_state <= wdt_pkg::wdt_ref_idle;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt <= CNT_MAX;                                              // RL13
    end else if (reload) begin
      cnt <= CNT_MAX;                                              // RL4
    end else if (count_pulse) begin
      cnt <= cnt - {{(CNT_W-1){1'b0}}, 1'b1};                      // RL1
    end
  end

  // Straps are caught on the first edge after reset release
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      strap_done <= 1'b0;
    end else begin
      strap_done <= 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      running <= 1'b0;
    end else if (!strap_done) begin
      running <= !auto_start_select_in;                            // RL9
    end else if (wr_in && (addr_in == `WDT_ADDR_START)) begin
      running <= 1'b1;                                             // RL5
    end
  end

  // Once on, protection cannot be turned off by software
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      protect <= 1'b0;
    end else if (!strap_done) begin
      protect <= !protect_after_reset_select_in;                   // RL10
    end else if (wr_in && (addr_in == `WDT_ADDR_PROTECT)
                 && wdata_in[`WDT_PROT_BIT]) begin
      protect <= 1'b1;                                             // RL2
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      presc_sel <= 1'b0;
    end else if (wr_in && (addr_in == `WDT_ADDR_CONTROL)) begin
      presc_sel <= wdata_in[`WDT_CTRL_PRESC_BIT];                  // RL11
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      urst_sel <= 1'b0;
    end else if (wr_in && (addr_in == `WDT_ADDR_CONFIG)) begin
      urst_sel <= wdata_in[`WDT_CFG_URST_BIT];
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wdt_reset_out <= 1'b0;
    end else begin
      wdt_reset_out <= underflow && (protect || urst_sel);          // RL7
    end
  end

  always_comb begin
    ev_set = '0;
    ev_set[`WDT_EV_UF_IRQ] = underflow && !protect && !urst_sel;   // RL7
    ev_set[`WDT_EV_UF_ANY] = underflow;
  end

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      status <= '0;
    end else if (wr_in && (addr_in == `WDT_ADDR_CLEAR)) begin
      status <= (status & ~wdata_in[`WDT_EV_W-1:0]) | ev_set;
    end else begin
      status <= status | ev_set;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      enable <= '0;
    end else if (wr_in && (addr_in == `WDT_ADDR_ENABLE)) begin
      enable <= wdata_in[`WDT_EV_W-1:0];
    end
  end

  assign irq_out = |(status & enable);

  // Reserved control bits read as zero; unmapped addresses read zero
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_out <= `WDT_RDATA_RST;
    end else if (rd_in) begin
      case (addr_in)
        `WDT_ADDR_CONTROL: rdata_out <= {presc_sel, 2'b00,
                                         cnt[CNT_W-1 -: `WDT_TOP_W]}; // RL12
        `WDT_ADDR_PROTECT: rdata_out <= {protect, 7'h00};
        `WDT_ADDR_CONFIG:  rdata_out <= {7'h00, urst_sel};
        `WDT_ADDR_STATUS:  rdata_out <= {6'h00, status};
        `WDT_ADDR_ENABLE:  rdata_out <= {6'h00, enable};
        default:           rdata_out <= `WDT_RDATA_RST;
      endcase
    end else begin
      rdata_out <= `WDT_RDATA_RST;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_arm;
    wr_refresh && (wdata_in == `WDT_REFRESH_ARM);
  endsequence
  sequence s_fire;
    wr_refresh && (wdata_in == `WDT_REFRESH_FIRE);
  endsequence

  property p_decrement;
    count_pulse && !reload
      |=> cnt == $past(cnt) - {{(CNT_W-1){1'b0}}, 1'b1};
  endproperty
  a_decrement: assert property (p_decrement) // RL1
    else $error("counter did not step down by one");

  property p_refresh;
    s_arm ##1 s_fire |=> cnt == CNT_MAX;
  endproperty
  a_refresh: assert property (p_refresh) // RL4
    else $error("refresh sequence did not reload counter");

  property p_underflow_load;
    underflow |=> cnt == CNT_MAX;
  endproperty
  a_underflow_load: assert property (p_underflow_load) // RL13
    else $error("underflow did not load all ones");

  property p_source;
    (protect && !loco_tick_in) || (!protect && !cpu_tick_in)
      |-> !count_pulse;
  endproperty
  a_source: assert property (p_source) // RL3
    else $error("wrong count source selected");

  property p_halt;
    halted && !reload |=> $stable(cnt);
  endproperty
  a_halt: assert property (p_halt) // RL6
    else $error("counter moved in stop or wait mode");

  property p_protect_reset;
    underflow && protect |-> !ev_set[`WDT_EV_UF_IRQ]
      ##1 (wdt_reset_out && status[`WDT_EV_UF_ANY]);
  endproperty
  a_protect_reset: assert property (p_protect_reset) // RL7
    else $error("protected underflow did not reset");

  property p_irq_mode;
    underflow && !protect && !urst_sel |=> !wdt_reset_out
                                           && status[`WDT_EV_UF_IRQ];
  endproperty
  a_irq_mode: assert property (p_irq_mode) // RL7
    else $error("interrupt-mode underflow misbehaved");

  property p_start;
    strap_done && wr_in && (addr_in == `WDT_ADDR_START) |=> running;
  endproperty
  a_start: assert property (p_start) // RL5
    else $error("start write did not start counter");

  property p_protect_sticky;
    protect |=> protect;
  endproperty
  a_protect_sticky: assert property (p_protect_sticky) // RL2
    else $error("protection dropped");

  property p_control_read;
    rd_in && (addr_in == `WDT_ADDR_CONTROL)
      |=> rdata_out[4:0] == $past(cnt[CNT_W-1 -: `WDT_TOP_W]);
  endproperty
  a_control_read: assert property (p_control_read) // RL12
    else $error("control read lost counter top bits");
endmodule
`default_nettype wire

// ### logic/wdt_consts.svh
// Watchdog constants: offsets, fields, reset values and divider counts
// Operation
// RL1 - 15-bit counter decrements per count tick
// RL2 - Protection mode selectable enabled or disabled
// RL3 - CPU clock unprotected, low-speed oscillator protected
// RL4 - Reinit on reset, underflow, 00h-then-FFh refresh
// RL5 - Start automatically or on start register write
// RL6 - Halt in stop/wait unless protection enabled
// RL7 - Underflow: interrupt or reset; protected always reset
// RL8 - Software refreshes after watchdog interrupt
// RL9 - Auto-start option 0 starts after reset
// RL10 - Protection option 0 enables protection after reset
// RL11 - Prescaler divides by 16 or 128
// RL12 - Control register bits 4-0 show counter top
// RL13 - Reinitialisation loads all ones
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH
`define WDT_CNT_W          15
`define WDT_TOP_W          5
`define WDT_ADDR_REFRESH   8'h0D
`define WDT_ADDR_START     8'h0E
`define WDT_ADDR_CONTROL   8'h0F
`define WDT_ADDR_PROTECT   8'h1C
`define WDT_ADDR_CONFIG    8'h1D
`define WDT_ADDR_STATUS    8'h20
`define WDT_ADDR_CLEAR     8'h21
`define WDT_ADDR_ENABLE    8'h22
`define WDT_REFRESH_ARM    8'h00
`define WDT_REFRESH_FIRE   8'hFF
`define WDT_CTRL_PRESC_BIT 7
`define WDT_PROT_BIT       7
`define WDT_CFG_URST_BIT   0
`define WDT_EV_W           2
`define WDT_EV_UF_IRQ      0
`define WDT_EV_UF_ANY      1
`define WDT_DIV_W          7
`define WDT_DIV16_LAST     7'h0F
`define WDT_DIV128_LAST    7'h7F
`define WDT_RDATA_RST      8'h00
`endif

// ### logic/wdt_pkg.sv
// Watchdog types
package wdt_pkg;
  typedef enum logic [1:0] {
    wdt_ref_idle  = 2'b01,
    wdt_ref_armed = 2'b10
  } wdt_ref_state_t;
endpackage

// ### logic/wdt_presc.sv
// Watchdog prescaler: divides count-source ticks by 16 or 128
`timescale 1ns/1ps
`default_nettype none
`include "wdt_consts.svh"
module wdt_presc (
  input  wire logic clock_in,   // System clock
  input  wire logic rst_b_in,   // Async reset, active low
  input  wire logic tick_in,    // Count-source tick, gated
  input  wire logic clr_in,     // Restart division
  input  wire logic sel_in,     // 0: /16, 1: /128
  output logic      pulse_out   // One tick per division
);
  logic [`WDT_DIV_W-1:0] div_cnt;
  logic [`WDT_DIV_W-1:0] last;

  assign last = sel_in ? `WDT_DIV128_LAST : `WDT_DIV16_LAST; // RL11

  // Pulse is combinational so the counter steps in the same cycle
  // Clear stays out of the pulse term: the core builds clear from it
  assign pulse_out = tick_in && (div_cnt >= last); // RL11

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_cnt <= '0;
    end else if (clr_in) begin
      div_cnt <= '0;
    end else if (tick_in) begin
      // A >= compare keeps a /128 to /16 switch from wrapping long
      if (div_cnt >= last) begin
        div_cnt <= '0;
      end else begin
        div_cnt <= div_cnt + 7'h01;
      end
    end
  end

  property p_div_wrap;
    @(posedge clock_in) disable iff (!rst_b_in)
    pulse_out |=> (div_cnt == 7'h00);
  endproperty
  a_div_wrap: assert property (p_div_wrap) // RL11
    else $error("prescaler did not restart after a pulse");
endmodule
`default_nettype wire

// ### sim/wdt_core_bench.sv
// Self-checking register-level bench for the watchdog timer core
`timescale 1ns/1ps
`default_nettype none
`include "wdt_consts.svh"
module wdt_core_bench;
  // Short counter keeps underflow reachable; top field is cnt[9:5]
  localparam int CW = 10;
  logic       clock_in;
  logic       rst_b_in;
  logic [7:0] addr_in;
  logic [7:0] wdata_in;
  logic       wr_in;
  logic       rd_in;
  logic [7:0] rdata_out;
  logic       cpu_tick_in;
  logic       loco_tick_in;
  logic       stop_mode_in;
  logic       wait_mode_in;
  logic       auto_sel;
  logic       prot_sel;
  logic       wdt_reset_out;
  logic       irq_out;
  logic [7:0] d;
  int         errors;
  int         checked;
  int         cycles;
  int         resets;

  wdt_core #(.CNT_W(CW)) DUT (
    .clock_in                      (clock_in),
    .rst_b_in                      (rst_b_in),
    .addr_in                       (addr_in),
    .wdata_in                      (wdata_in),
    .wr_in                         (wr_in),
    .rd_in                         (rd_in),
    .rdata_out                     (rdata_out),
    .cpu_tick_in                   (cpu_tick_in),
    .loco_tick_in                  (loco_tick_in),
    .stop_mode_in                  (stop_mode_in),
    .wait_mode_in                  (wait_mode_in),
    .auto_start_select_in          (auto_sel),
    .protect_after_reset_select_in (prot_sel),
    .wdt_reset_out                 (wdt_reset_out),
    .irq_out                       (irq_out)
  );

  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end

  task automatic test_done();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] got,
                     input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic run(input int n);
    repeat (n) @(posedge clock_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_in);
    addr_in  <= a;
    wdata_in <= v;
    wr_in    <= 1'b1;
    @(posedge clock_in);
    wr_in    <= 1'b0;
  endtask

  // Read data is valid only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clock_in);
    rd_in   <= 1'b0;
    #1;
    v = rdata_out;
  endtask

  // Back-to-back refresh writes with the strobe held high
  task automatic refresh();
    @(posedge clock_in);
    addr_in  <= `WDT_ADDR_REFRESH;
    wdata_in <= `WDT_REFRESH_ARM;
    wr_in    <= 1'b1;
    @(posedge clock_in);
    wdata_in <= `WDT_REFRESH_FIRE;
    @(posedge clock_in);
    wr_in    <= 1'b0;
  endtask

  task automatic wait_hi(input bit sel, input int lim);
    logic found;
    found = 1'b0;
    for (int i = 0; i < lim && !found; i++) begin
      @(posedge clock_in);
      #1;
      if (sel ? (wdt_reset_out === 1'b1) : (irq_out === 1'b1)) found = 1'b1;
    end
    chk("event seen", {7'h00, found}, 8'h01);
  endtask

  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (wdt_reset_out === 1'b1) resets <= resets + 1;
    if (cycles == 90000) begin
      errors++;
      test_done();
    end
  end

  initial begin
    errors = 0; checked = 0; cycles = 0; resets = 0;
    rst_b_in = 1'b0; addr_in = 8'h00; wdata_in = 8'h00;
    wr_in = 1'b0; rd_in = 1'b0; cpu_tick_in = 1'b1; loco_tick_in = 1'b0;
    stop_mode_in = 1'b0; wait_mode_in = 1'b0; auto_sel = 1'b0; prot_sel = 1'b1;
    run(20);
    rst_b_in <= 1'b1;
    run(2);
    rd(`WDT_ADDR_CONTROL, d); chk("control", d, 8'h1F);
    rd(`WDT_ADDR_STATUS, d); chk("status", d, 8'h00);
    rd(8'h3F, d); chk("unmapped", d, 8'h00);
    rd(`WDT_ADDR_PROTECT, d); chk("protect", d, 8'h00);
    run(768);
    rd(`WDT_ADDR_CONTROL, d); chk("control", d, 8'h1E);
    // A foreign write between the two refresh values breaks the sequence
    wr(`WDT_ADDR_REFRESH, 8'h00);
    wr(`WDT_ADDR_REFRESH, 8'h55);
    wr(`WDT_ADDR_REFRESH, 8'hFF);
    rd(`WDT_ADDR_CONTROL, d); chk("control", d, 8'h1E);
    // Idle cycle between the two refresh values keeps the sequence
    wr(`WDT_ADDR_REFRESH, `WDT_REFRESH_ARM);
    wr(`WDT_ADDR_REFRESH, `WDT_REFRESH_FIRE);
    rd(`WDT_ADDR_CONTROL, d); chk("control", d, 8'h1F);
    wr(`WDT_ADDR_CONTROL, 8'h80);
    refresh();
    run(768);
    rd(`WDT_ADDR_CONTROL, d); chk("control", d, 8'h9F);
    run(5400);
    rd(`WDT_ADDR_CONTROL, d); chk("control", d, 8'h9E);
    wr(`WDT_ADDR_CONTROL, 8'h00);
    for (int i = 0; i < 2; i++) begin
      refresh();
      stop_mode_in <= (i == 0);
      wait_mode_in <= (i == 1);
      run(768);
      rd(`WDT_ADDR_CONTROL, d); chk("control", d, 8'h1F);
      stop_mode_in <= 1'b0;
      wait_mode_in <= 1'b0;
    end
    wr(`WDT_ADDR_ENABLE, 8'h01);
    wr(`WDT_ADDR_CONFIG, 8'h00);
    refresh();
    wait_hi(1'b0, 17000);
    rd(`WDT_ADDR_STATUS, d); chk("status", d, 8'h03);
    rd(`WDT_ADDR_ENABLE, d); chk("enable", d, 8'h01);
    rd(`WDT_ADDR_CONFIG, d); chk("config", d, 8'h00);
    rd(`WDT_ADDR_CONTROL, d); chk("control", d, 8'h1F);
    chk("resets", 8'(resets), 8'h00);
    // Let the write edge settle before looking at the level output
    wr(`WDT_ADDR_ENABLE, 8'h00);
    #1;
    chk("irq", {7'h00, irq_out}, 8'h00);
    wr(`WDT_ADDR_ENABLE, 8'h01);
    #1;
    chk("irq", {7'h00, irq_out}, 8'h01);
    wr(`WDT_ADDR_CLEAR, 8'h01);
    #1;
    chk("irq", {7'h00, irq_out}, 8'h00);
    rd(`WDT_ADDR_STATUS, d); chk("status", d, 8'h02);
    refresh();
    wr(`WDT_ADDR_CLEAR, 8'h03);
    wr(`WDT_ADDR_CONFIG, 8'h01);
    refresh();
    wait_hi(1'b1, 17000);
    @(posedge clock_in);
    #1;
    chk("reset pulse end", {7'h00, wdt_reset_out}, 8'h00);
    rd(`WDT_ADDR_STATUS, d); chk("status", d, 8'h02);
    chk("resets", 8'(resets), 8'h01);
    wr(`WDT_ADDR_CONFIG, 8'h00);
    wr(`WDT_ADDR_CLEAR, 8'h03);
    wr(`WDT_ADDR_PROTECT, 8'h80);
    wr(`WDT_ADDR_PROTECT, 8'h00);
    rd(`WDT_ADDR_PROTECT, d); chk("protect", d, 8'h80);
    refresh();
    run(768);
    rd(`WDT_ADDR_CONTROL, d); chk("control", d, 8'h1F);
    loco_tick_in <= 1'b1;
    stop_mode_in <= 1'b1;
    refresh();
    run(768);
    rd(`WDT_ADDR_CONTROL, d); chk("control", d, 8'h1E);
    wait_hi(1'b1, 17000);
    rd(`WDT_ADDR_STATUS, d); chk("status", d, 8'h02);
    chk("irq", {7'h00, irq_out}, 8'h00);
    // Second reset with the opposite straps
    rst_b_in <= 1'b0;
    auto_sel <= 1'b1;
    prot_sel <= 1'b0;
    run(20);
    rst_b_in <= 1'b1;
    run(2);
    rd(`WDT_ADDR_PROTECT, d); chk("protect", d, 8'h80);
    run(768);
    rd(`WDT_ADDR_CONTROL, d); chk("control", d, 8'h1F);
    wr(`WDT_ADDR_START, 8'h5A);
    run(768);
    rd(`WDT_ADDR_CONTROL, d); chk("control", d, 8'h1E);
    test_done();
  end
endmodule
`default_nettype wire
